/* src/sacc_top.sv */
// Digital control of a 10-bit successive-approximation converter with an
// AXI4-Lite register slave.
// Assumes trigger inputs and converter data come from logic on SYS_CLK.
`timescale 1ns/1ps

// Function
// - Converter runs and draws power only while converter_enable is set
// - Reference and channel selection reach the converter only when enabled
// - 10-bit result split over two bytes, right or left aligned
// - Reading the low byte blocks result updates; blocked results are lost
// - Reading the high byte lifts the update block
// - Completion flag is raised even when the result is lost
// - Writing start begins a conversion; start reads one while converting
// - Channel change mid-conversion applies only once the converter is idle, not between free-run conversions
// - Auto trigger enabled by its bit, source chosen by trigger select
// - Trigger rising edge resets the prescaler and starts a conversion
// - Trigger still high at completion starts nothing
// - Trigger edges during a conversion are ignored
// - Trigger source flags act as levels regardless of interrupt enables
// - Completion flag as source restarts at every completion, cleared or not
// - Start still works while auto triggering is enabled
// - Code zero is ground, full scale is reference minus one step
// - Reference select routes supply or internal reference to the pin
// - Channel select covers single-ended and gained differential inputs
// - Completion stores result, sets flag and clears single-mode start
// - Conversion lasts 13 converter clocks, the first after enable 25
// - Prescaler runs while enabled and is held in reset otherwise
module sacc_top
(
  input  wire logic                      SYS_CLK,
  input  wire logic                      SYS_RST,
  input  wire logic [sacc_pkg::SACC_AW-1:0] AWADDR,
  input  wire logic                      AWVALID,
  output logic                           AWREADY,
  input  wire logic [31:0]               WDATA,
  input  wire logic [3:0]                WSTRB,
  input  wire logic                      WVALID,
  output logic                           WREADY,
  output logic [1:0]                     BRESP,
  output logic                           BVALID,
  input  wire logic                      BREADY,
  input  wire logic [sacc_pkg::SACC_AW-1:0] ARADDR,
  input  wire logic                      ARVALID,
  output logic                           ARREADY,
  output logic [31:0]                    RDATA,
  output logic [1:0]                     RRESP,
  output logic                           RVALID,
  input  wire logic                      RREADY,
  input  wire logic [7:1]                TRIG_IN,
  input  wire logic [9:0]                ADC_DATA,
  output logic                           ADC_POWER_ON,
  output logic [1:0]                     ADC_REF_SEL,
  output logic [4:0]                     ADC_CHAN_SEL,
  output logic                           ADC_GAIN_BYPASS,
  output logic                           ADC_CONVERTING,
  output logic                           ADC_DONE
);
  import sacc_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic                en_reg, auto_reg, flag_reg, start_req_reg, lock_reg, first_reg;
  logic [2:0]          ps_reg, ts_reg;
  logic [7:0]          mux_reg;
  logic [9:0]          result_reg;
  logic [6:0]          presc_reg;
  logic [4:0]          cnt_reg, len_reg;
  logic                trig_prev_reg;
  sacc_state_e         state_reg;
  logic                awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic                aw_got_reg, w_got_reg;
  logic [7:0]          waddr_reg;
  logic [7:0]          wbyte_reg;
  logic                wlane_reg;
  logic [1:0]          bresp_reg, rresp_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          ref_out_reg;
  logic [4:0]          chan_out_reg;
  logic                power_reg, bypass_reg, conv_out_reg, done_out_reg;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        aw_fire   = AWVALID & awready_reg;
  wire        w_fire    = WVALID & wready_reg;
  wire        wr_do     = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire        ar_fire   = ARVALID & arready_reg;
  wire        wr_a      = wr_do & wlane_reg & (waddr_reg == SACC_OFF_CTRL_A);
  wire        wr_b      = wr_do & wlane_reg & (waddr_reg == SACC_OFF_CTRL_B);
  wire        wr_m      = wr_do & wlane_reg & (waddr_reg == SACC_OFF_MUX);
  wire        wr_ok     = (waddr_reg == SACC_OFF_CTRL_A) | (waddr_reg == SACC_OFF_CTRL_B)
                        | (waddr_reg == SACC_OFF_MUX);
  wire [7:0]  raddr     = {ARADDR[7:2], 2'b00};
  wire        rd_low    = ar_fire & (raddr == SACC_OFF_RES_LOW);
  wire        rd_high   = ar_fire & (raddr == SACC_OFF_RES_HIGH);
  wire        busy      = (state_reg == SACC_CONV);
  wire [7:0]  ctrl_a_rd = {en_reg, start_req_reg | busy, auto_reg, flag_reg, 1'b0, ps_reg};
  // Alignment is applied when read, so the left-adjust bit acts at once
  wire [15:0] res_word  = mux_reg[SACC_M_LEFT] ? {result_reg, 6'h00}
                                               : {6'h00, result_reg};
  wire        rd_ok     = (raddr <= SACC_OFF_RES_HIGH);
  wire [7:0]  rd_byte   = (raddr == SACC_OFF_CTRL_A)   ? ctrl_a_rd :
                          (raddr == SACC_OFF_CTRL_B)   ? {5'h00, ts_reg} :
                          (raddr == SACC_OFF_MUX)      ? mux_reg :
                          (raddr == SACC_OFF_RES_LOW)  ? res_word[7:0] :
                          (raddr == SACC_OFF_RES_HIGH) ? res_word[15:8] : 8'h00;

  // ****************************************************************
  // Prescaler, trigger and conversion control
  // ****************************************************************
  wire        en_next    = wr_a ? wbyte_reg[SACC_A_ENABLE] : en_reg;
  wire [7:0]  ps_full    = 8'(8'h01 << ps_reg) - 8'h01;
  wire [6:0]  ps_lim     = (ps_reg < 3'h2) ? SACC_PS_MIN_LIM : ps_full[6:0];
  // At-least compare: a smaller divide picked mid-count cannot wrap the counter
  wire        tick       = en_reg & (presc_reg >= ps_lim);
  wire        free_run   = auto_reg & (ts_reg == SACC_TS_FREE_RUN);
  // Source flags are plain levels here, so masked interrupts still trigger
  wire        trig_lvl   = TRIG_IN[ts_reg == 3'h0 ? 3'h1 : ts_reg];
  // A level still high after a conversion gives no new edge
  wire        trig_edge  = trig_lvl & ~trig_prev_reg;
  wire        auto_start = en_reg & en_next & auto_reg & ~free_run & trig_edge
                         & ~busy & ~start_req_reg;
  wire        sw_start   = wr_a & wbyte_reg[SACC_A_START] & en_next;
  wire        conv_begin = en_reg & ~busy & start_req_reg & tick;
  // A conversion cut short by disabling never completes, so nothing is flagged
  wire        done       = busy & tick & en_next & (cnt_reg == len_reg - 5'h01);
  wire        flag_clr   = wr_a & wbyte_reg[SACC_A_FLAG];

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      presc_reg <= 7'h00;
    else if (~en_reg | auto_start | tick)
      presc_reg <= 7'h00;
    else
      presc_reg <= presc_reg + 7'h01;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      trig_prev_reg <= 1'b0;
    else
      trig_prev_reg <= trig_lvl;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      state_reg <= SACC_IDLE;
      cnt_reg   <= 5'h00;
      len_reg   <= SACC_NORMAL_CYCLES;
      first_reg <= 1'b1;
    end
    else if (~en_next)
    begin
      // Disabling aborts; the next conversion re-initialises the analog side
      state_reg <= SACC_IDLE;
      cnt_reg   <= 5'h00;
      first_reg <= 1'b1;
    end
    else if (conv_begin)
    begin
      state_reg <= SACC_CONV;
      cnt_reg   <= 5'h00;
      len_reg   <= first_reg ? SACC_FIRST_CYCLES : SACC_NORMAL_CYCLES;
      first_reg <= 1'b0;
    end
    else if (done)
    begin
      state_reg <= free_run ? SACC_CONV : SACC_IDLE;
      cnt_reg   <= 5'h00;
      len_reg   <= SACC_NORMAL_CYCLES;
    end
    else if (busy & tick)
      cnt_reg <= cnt_reg + 5'h01;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      start_req_reg <= 1'b0;
    else if (~en_next | conv_begin)
      start_req_reg <= 1'b0;
    else if (sw_start | auto_start)
      start_req_reg <= 1'b1;
  end

  // ****************************************************************
  // Result bytes, lock and completion flag
  // ****************************************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      result_reg <= SACC_RST_RESULT;
    else if (done & ~lock_reg)
      result_reg <= ADC_DATA;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      lock_reg <= 1'b0;
    else if (rd_high)
      lock_reg <= 1'b0;
    else if (rd_low)
      lock_reg <= 1'b1;
  end

  // Set wins over a clear in the same cycle so no completion is missed
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      flag_reg <= 1'b0;
    else if (done)
      flag_reg <= 1'b1;
    else if (flag_clr)
      flag_reg <= 1'b0;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      en_reg   <= SACC_RST_CTRL_A[SACC_A_ENABLE];
      auto_reg <= SACC_RST_CTRL_A[SACC_A_AUTO];
      ps_reg   <= SACC_RST_CTRL_A[SACC_A_PS_LSB +: 3];
      ts_reg   <= SACC_RST_TS;
      mux_reg  <= SACC_RST_MUX;
    end
    else
    begin
      if (wr_a)
      begin
        en_reg   <= wbyte_reg[SACC_A_ENABLE];
        auto_reg <= wbyte_reg[SACC_A_AUTO];
        ps_reg   <= wbyte_reg[SACC_A_PS_LSB +: 3];
      end
      if (wr_b)
        ts_reg <= wbyte_reg[SACC_B_TS_LSB +: 3];
      if (wr_m)
        mux_reg <= wbyte_reg;
    end
  end

  // ****************************************************************
  // Converter-side outputs
  // ****************************************************************
  // Selection tracks the register only while idle, and only when enabled
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      ref_out_reg  <= 2'h0;
      chan_out_reg <= 5'h00;
      bypass_reg   <= 1'b1;
    end
    else if (~en_reg)
    begin
      ref_out_reg  <= 2'h0;
      chan_out_reg <= 5'h00;
      bypass_reg   <= 1'b1;
    end
    else if (~busy & ~conv_begin)
    begin
      ref_out_reg  <= mux_reg[SACC_M_REF_LSB +: 2];
      chan_out_reg <= mux_reg[SACC_M_CH_LSB +: 5];
      bypass_reg   <= (mux_reg[SACC_M_CH_LSB +: 5] <= SACC_SINGLE_LAST);
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      power_reg    <= 1'b0;
      conv_out_reg <= 1'b0;
      done_out_reg <= 1'b0;
    end
    else
    begin
      power_reg    <= en_reg;
      conv_out_reg <= busy;
      done_out_reg <= done;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= SACC_RESP_OKAY;
      waddr_reg   <= 8'h00;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
    end
    else
    begin
      awready_reg <= ~(aw_fire | (aw_got_reg & ~wr_do));
      wready_reg  <= ~(w_fire | (w_got_reg & ~wr_do));
      if (aw_fire)
        waddr_reg <= {AWADDR[7:2], 2'b00};
      if (w_fire)
      begin
        wbyte_reg <= WDATA[7:0];
        wlane_reg <= WSTRB[0];
      end
      aw_got_reg <= aw_fire | (aw_got_reg & ~wr_do);
      w_got_reg  <= w_fire | (w_got_reg & ~wr_do);
      if (wr_do)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? SACC_RESP_OKAY : SACC_RESP_SLVERR;
      end
      else if (BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= SACC_RESP_OKAY;
    end
    else
    begin
      arready_reg <= ~ar_fire & ~(rvalid_reg & ~RREADY);
      if (ar_fire)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= {24'h00_0000, rd_byte};
        rresp_reg  <= rd_ok ? SACC_RESP_OKAY : SACC_RESP_SLVERR;
      end
      else if (RREADY)
        rvalid_reg <= 1'b0;
    end
  end

  assign AWREADY         = awready_reg;
  assign WREADY          = wready_reg;
  assign BVALID          = bvalid_reg;
  assign BRESP           = bresp_reg;
  assign ARREADY         = arready_reg;
  assign RVALID          = rvalid_reg;
  assign RDATA           = rdata_reg;
  assign RRESP           = rresp_reg;
  assign ADC_POWER_ON    = power_reg;
  assign ADC_REF_SEL     = ref_out_reg;
  assign ADC_CHAN_SEL    = chan_out_reg;
  assign ADC_GAIN_BYPASS = bypass_reg;
  assign ADC_CONVERTING  = conv_out_reg;
  assign ADC_DONE        = done_out_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_off_idle;
    @(posedge SYS_CLK) disable iff (SYS_RST) !en_reg |-> ##1 (!busy && !ADC_POWER_ON);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("converter active while disabled");

  property p_sel_gated;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (!en_reg ##1 !en_reg) |-> (ADC_CHAN_SEL == 5'h00 && ADC_REF_SEL == 2'h0);
  endproperty
  a_sel_gated: assert property (p_sel_gated) else $error("selection leaked while disabled");

  property p_lock_keeps;
    @(posedge SYS_CLK) disable iff (SYS_RST) (done && lock_reg) |=> $stable(result_reg);
  endproperty
  a_lock_keeps: assert property (p_lock_keeps) else $error("locked result was overwritten");

  property p_unlock;
    @(posedge SYS_CLK) disable iff (SYS_RST) rd_high |=> !lock_reg;
  endproperty
  a_unlock: assert property (p_unlock) else $error("high byte read left lock set");

  property p_flag_set;
    @(posedge SYS_CLK) disable iff (SYS_RST) done |=> (flag_reg && ADC_DONE);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("completion did not set flag");

  property p_sw_start;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (sw_start && !busy && en_reg) |=> ##[0:130] busy;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("start write did not convert");

  property p_chan_hold;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (busy && $past(busy) && en_reg) |-> $stable(ADC_CHAN_SEL);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid-conversion");

  property p_trig_reset;
    @(posedge SYS_CLK) disable iff (SYS_RST) auto_start |=> (presc_reg == 7'h00 && start_req_reg);
  endproperty
  a_trig_reset: assert property (p_trig_reset) else $error("trigger edge ignored");

  property p_busy_edge;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (busy && trig_edge && !sw_start && !free_run) |=> !start_req_reg;
  endproperty
  a_busy_edge: assert property (p_busy_edge) else $error("edge accepted while busy");

  property p_free_run;
    @(posedge SYS_CLK) disable iff (SYS_RST) (done && free_run && en_next) |=> busy;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run did not restart");

  property p_first_len;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (conv_begin && first_reg) |=> (len_reg == SACC_FIRST_CYCLES);
  endproperty
  a_first_len: assert property (p_first_len) else $error("first conversion length wrong");

  property p_presc_hold;
    @(posedge SYS_CLK) disable iff (SYS_RST) !en_reg |=> (presc_reg == 7'h00);
  endproperty
  a_presc_hold: assert property (p_presc_hold) else $error("prescaler ran while disabled");

  c_locked_done: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) done && lock_reg);
  c_free_run:    cover property (@(posedge SYS_CLK) disable iff (SYS_RST) done && free_run);
  c_auto_start:  cover property (@(posedge SYS_CLK) disable iff (SYS_RST) auto_start);

endmodule // sacc_top

/* src/sacc_pkg.sv */
// Constants of the converter control block: register map, field positions,
// reset values and conversion timing.
// Assumes a 32-bit AXI4-Lite bus with byte addresses and 8-bit registers.
package sacc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          SACC_AW            = 8;
  localparam logic [7:0]  SACC_OFF_CTRL_A    = 8'h00;
  localparam logic [7:0]  SACC_OFF_CTRL_B    = 8'h04;
  localparam logic [7:0]  SACC_OFF_MUX       = 8'h08;
  localparam logic [7:0]  SACC_OFF_RES_LOW   = 8'h0C;
  localparam logic [7:0]  SACC_OFF_RES_HIGH  = 8'h10;
  localparam logic [1:0]  SACC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  SACC_RESP_SLVERR   = 2'h2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int          SACC_A_ENABLE      = 7;
  localparam int          SACC_A_START       = 6;
  localparam int          SACC_A_AUTO        = 5;
  localparam int          SACC_A_FLAG        = 4;
  localparam int          SACC_A_PS_LSB      = 0;
  localparam int          SACC_B_TS_LSB      = 0;
  localparam int          SACC_M_REF_LSB     = 6;
  localparam int          SACC_M_LEFT        = 5;
  localparam int          SACC_M_CH_LSB      = 0;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0]  SACC_RST_CTRL_A    = 8'h00;
  localparam logic [2:0]  SACC_RST_TS        = 3'h0;
  localparam logic [7:0]  SACC_RST_MUX       = 8'h00;
  localparam logic [9:0]  SACC_RST_RESULT    = 10'h000;
  localparam logic [2:0]  SACC_TS_FREE_RUN   = 3'h0;
  localparam logic [4:0]  SACC_SINGLE_LAST   = 5'h07;
  localparam logic [4:0]  SACC_FIRST_CYCLES  = 5'h19;
  localparam logic [4:0]  SACC_NORMAL_CYCLES = 5'h0D;
  localparam logic [6:0]  SACC_PS_MIN_LIM    = 7'h01;

  typedef enum logic [0:0] {
    SACC_IDLE = 1'b0,
    SACC_CONV = 1'b1
  } sacc_state_e;

endpackage

/* verification/sacc_core_model.sv */
// Behavioural model of the analog core behind the converter control.
// Assumes done pulses arrive on the same clock as the control logic.
`timescale 1ns/1ps
module sacc_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       power_on,
  input  wire logic       done,
  output logic      [9:0] data
);
  logic [4:0] cnt_reg;
  // Results repeat only every 32 completions; an unpowered core shows garbage, never a stale code
  assign data = power_on ? {cnt_reg, 5'h13} : ~{cnt_reg, 5'h13};
  always_ff @(posedge clk)
  begin
    if (rst) cnt_reg <= 5'h00;
    else if (done) cnt_reg <= cnt_reg + 5'h01;
  end
endmodule // sacc_core_model

/* verification/sar_adc_conversion_control_bench.sv */
// Self-checking bench of the converter control over its register bus.
// Assumes the analog core model beside it and the design package.
`timescale 1ns/1ps
module sar_adc_conversion_control_bench;
  import sacc_pkg::*;
  logic        SYS_CLK, SYS_RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic        ADC_POWER_ON, ADC_GAIN_BYPASS, ADC_CONVERTING, ADC_DONE;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rdv;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, ADC_REF_SEL, brs, rrs;
  logic [7:1]  TRIG_IN;
  logic [9:0]  ADC_DATA;
  logic [4:0]  ADC_CHAN_SEL;
  int          err_count, samples_checked, cyc, done_cnt, n, d0;

  sacc_top dut (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .TRIG_IN(TRIG_IN), .ADC_DATA(ADC_DATA), .ADC_POWER_ON(ADC_POWER_ON),
    .ADC_REF_SEL(ADC_REF_SEL), .ADC_CHAN_SEL(ADC_CHAN_SEL), .ADC_GAIN_BYPASS(ADC_GAIN_BYPASS),
    .ADC_CONVERTING(ADC_CONVERTING), .ADC_DONE(ADC_DONE));
  sacc_core_model core (.clk(SYS_CLK), .rst(SYS_RST), .power_on(ADC_POWER_ON),
    .done(ADC_DONE), .data(ADC_DATA));

  initial
  begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // Cycle ceiling cuts a hang short; the whole run needs under 1500 cycles
  always @(posedge SYS_CLK)
  begin
    cyc <= cyc + 1;
    if (ADC_DONE) done_cnt <= done_cnt + 1;
    if (cyc == 4000)
    begin
      err_count++;
      close_out;
    end
  end

  // ********************************
  // Shared tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    AWADDR  <= a;
    WDATA   <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do
    begin
      @(posedge SYS_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    brs = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do
    begin
      @(posedge SYS_CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    rdv = RDATA;
    rrs = RRESP;
    RREADY <= 1'b0;
  endtask

  // Completion pulse lasts one cycle, so it is sampled at every edge
  task automatic wait_done();
    n = 0;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end while (!ADC_DONE && n < 200);
    chk(ADC_DONE, 1'b1);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_single();
    rd(8'h14);
    chk(rrs, SACC_RESP_SLVERR);
    wr(8'h14, 8'hFF);
    chk(brs, SACC_RESP_SLVERR);
    wr(SACC_OFF_MUX, 8'h49);
    repeat (2) @(posedge SYS_CLK);
    chk({ADC_POWER_ON, ADC_REF_SEL, ADC_CHAN_SEL, ADC_GAIN_BYPASS}, 9'h001);
    wr(SACC_OFF_CTRL_A, 8'h80);
    repeat (2) @(posedge SYS_CLK);
    chk({ADC_POWER_ON, ADC_REF_SEL, ADC_CHAN_SEL, ADC_GAIN_BYPASS}, 9'h152);
    wr(SACC_OFF_MUX, 8'h43);
    wr(SACC_OFF_CTRL_A, 8'hC0);
    wait_done();
    chk(n inside {[46:56]}, 1'b1);
    rd(SACC_OFF_CTRL_A);
    chk(rdv, 32'h90);
    rd(SACC_OFF_RES_LOW);
    chk(rdv, 32'h13);
    rd(SACC_OFF_RES_HIGH);
    chk(rdv, 32'h00);
    $display("single conversion test done");
  endtask

  task automatic t_lock();
    wr(SACC_OFF_MUX, 8'h63);
    wr(SACC_OFF_CTRL_A, 8'hD0);
    wait_done();
    chk(n inside {[22:32]}, 1'b1);
    rd(SACC_OFF_RES_LOW);
    chk(rdv, 32'hC0);
    wr(SACC_OFF_CTRL_A, 8'hD0);
    wait_done();
    rd(SACC_OFF_CTRL_A);
    chk(rdv, 32'h90);
    rd(SACC_OFF_RES_HIGH);
    chk(rdv, 32'h0C);
    wr(SACC_OFF_CTRL_A, 8'hD0);
    wr(SACC_OFF_MUX, 8'h65);
    rd(SACC_OFF_CTRL_A);
    chk(rdv[6], 1'b1);
    chk(ADC_CHAN_SEL, 5'h03);
    chk(ADC_CONVERTING, 1'b1);
    wait_done();
    repeat (2) @(posedge SYS_CLK);
    chk(ADC_CHAN_SEL, 5'h05);
    chk(ADC_CONVERTING, 1'b0);
    rd(SACC_OFF_RES_LOW);
    chk(rdv, 32'hC0);
    rd(SACC_OFF_RES_HIGH);
    chk(rdv, 32'h1C);
    // Divide by eight: thirteen converter clocks of eight cycles each
    wr(SACC_OFF_CTRL_A, 8'hD3);
    wait_done();
    chk(n inside {[100:120]}, 1'b1);
    $display("result lock test done");
  endtask

  // Edge mid-conversion, a held level and an unselected line must add nothing
  task automatic t_auto();
    wr(SACC_OFF_CTRL_B, 8'h02);
    wr(SACC_OFF_CTRL_A, 8'hB0);
    d0 = done_cnt;
    TRIG_IN[2] <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    TRIG_IN[2] <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    TRIG_IN[2] <= 1'b1;
    repeat (40) @(posedge SYS_CLK);
    TRIG_IN[1] <= 1'b1;
    repeat (40) @(posedge SYS_CLK);
    chk(done_cnt - d0, 1);
    wr(SACC_OFF_CTRL_A, 8'hE0);
    wait_done();
    chk(n inside {[22:32]}, 1'b1);
    TRIG_IN <= 7'h00;
    $display("auto trigger test done");
  endtask

  task automatic t_free();
    wr(SACC_OFF_CTRL_B, 8'h00);
    wr(SACC_OFF_CTRL_A, 8'hE0);
    d0 = done_cnt;
    repeat (160) @(posedge SYS_CLK);
    chk(done_cnt - d0 >= 5, 1'b1);
    chk(ADC_CONVERTING, 1'b1);
    rd(SACC_OFF_CTRL_A);
    chk(rdv[6], 1'b1);
    wr(SACC_OFF_CTRL_A, 8'h00);
    d0 = done_cnt;
    repeat (60) @(posedge SYS_CLK);
    chk(done_cnt - d0, 0);
    chk({ADC_POWER_ON, ADC_REF_SEL, ADC_CHAN_SEL, ADC_GAIN_BYPASS}, 9'h001);
    $display("free running test done");
  endtask

  initial
  begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    WSTRB = 4'hF;
    TRIG_IN = 7'h00;
    SYS_RST = 1'b1;
    repeat (6) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    t_single();
    t_lock();
    t_auto();
    t_free();
    close_out();
  end
endmodule // sar_adc_conversion_control_bench
